// *** verilog/spio_port.sv ***
/*
 * Shared parallel I/O port: direction, output latch, registered pin
 * sampler and analog pin configuration, with peripheral override muxes.
 * Assumes pads resolve the wire from pad_oe_o; inputs synchronous to mclk_i.
 */
`default_nettype none

// What this block does
// - Active peripheral disables port driver, pin readable
// - Idle enabled peripheral leaves pin to port
// - Direction bit 1 input, 0 output
// - Reset makes every pin an input
// - Latch reads latch, writes only latch
// - Level reads pins, writes go to latch
// - Unimplemented bits disabled and read zero
// - Output and enable muxes favour peripheral
// - Input-only shared pin acts as dedicated
// - Analog pins read low in level register
// - Analog select needs analog bit and input
module spio_port (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [spio_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [spio_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [spio_pkg::PIN_W-1:0] pad_in_i,
   output logic [spio_pkg::PIN_W-1:0] pad_out_o,
   output logic [spio_pkg::PIN_W-1:0] pad_oe_o,
   input wire logic [spio_pkg::PIN_W-1:0] periph_drive_i,
   input wire logic [spio_pkg::PIN_W-1:0] periph_out_i,
   output logic [spio_pkg::PIN_W-1:0] analog_input_pins_o
);
   localparam int W = spio_pkg::PIN_W;

   logic [W-1:0] pin_direction_reg_q;
   logic [W-1:0] output_latch_reg_q;
   logic [W-1:0] analog_pin_config_reg_q;
   logic [W-1:0] pin_sample_q;
   logic [W-1:0] pin_level_reg;
   logic [W-1:0] analog_sel;
   logic [W-1:0] wr_val;
   logic [spio_pkg::ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have_q;
   logic w_have_q;
   logic wr_fire;
   logic [spio_pkg::ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   // ****************************************************************
   // Pad muxes
   // ****************************************************************
   // Input-only functions never assert periph_drive_i, so such
   // pins behave as dedicated port pins.
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_pin
         always_comb begin
            if (!spio_pkg::IMPL_MASK[g]) begin
               pad_out_o[g] = 1'b0;
               pad_oe_o[g] = 1'b0;
            end else if (periph_drive_i[g]) begin
               pad_out_o[g] = periph_out_i[g];
               pad_oe_o[g] = 1'b1;
            end else begin
               pad_out_o[g] = output_latch_reg_q[g];
               pad_oe_o[g] = ~pin_direction_reg_q[g];
            end
         end
      end
   endgenerate

   // Only input-direction pins feed the converter
   assign analog_sel = analog_pin_config_reg_q & pin_direction_reg_q
                       & spio_pkg::IMPL_MASK;
   assign analog_input_pins_o = analog_sel;

   // ****************************************************************
   // Pin sampler
   // ****************************************************************
   // One-cycle lag here is why software needs a gap before reading
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pin_sample_q <= '0;
      end else begin
         pin_sample_q <= pad_in_i & spio_pkg::IMPL_MASK;
      end
   end
   assign pin_level_reg = pin_sample_q & ~analog_sel;

   // ****************************************************************
   // AXI4-Lite write path
   // ****************************************************************
   assign s_axi_awready_o = ~aw_have_q & ~s_axi_bvalid_o;
   assign s_axi_wready_o = ~w_have_q & ~s_axi_bvalid_o;
   assign wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr_i;
   assign wr_data = w_have_q ? wdata_q : s_axi_wdata_i;
   assign wr_strb = w_have_q ? wstrb_q : s_axi_wstrb_i;
   assign wr_fire = (aw_have_q | (s_axi_awvalid_i & s_axi_awready_o))
                    & (w_have_q | (s_axi_wvalid_i & s_axi_wready_o));

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= spio_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_o <= 1'b1;
         unique case (wr_addr)
            spio_pkg::OFS_DIR, spio_pkg::OFS_LAT,
            spio_pkg::OFS_LVL, spio_pkg::OFS_ANA:
               s_axi_bresp_o <= spio_pkg::RESP_OKAY;
            default: s_axi_bresp_o <= spio_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // Byte strobes merged onto the 16-bit registers
   function automatic logic [W-1:0] merge(input logic [W-1:0] old);
      logic [W-1:0] r;
      r = old;
      if (wr_strb[0]) begin
         r[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
         r[15:8] = wr_data[15:8];
      end
      return r & spio_pkg::IMPL_MASK;
   endfunction

   assign wr_val = merge(output_latch_reg_q);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pin_direction_reg_q <= spio_pkg::DIR_RST
                                & spio_pkg::IMPL_MASK;
      end else if (wr_fire && wr_addr == spio_pkg::OFS_DIR) begin
         pin_direction_reg_q <= merge(pin_direction_reg_q);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         output_latch_reg_q <= spio_pkg::LAT_RST;
      end else if (wr_fire && (wr_addr == spio_pkg::OFS_LAT ||
                               wr_addr == spio_pkg::OFS_LVL)) begin
         output_latch_reg_q <= wr_val;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         analog_pin_config_reg_q <= spio_pkg::ANA_RST;
      end else if (wr_fire && wr_addr == spio_pkg::OFS_ANA) begin
         analog_pin_config_reg_q <= merge(analog_pin_config_reg_q);
      end
   end

   // ****************************************************************
   // AXI4-Lite read path
   // ****************************************************************
   assign s_axi_arready_o = ~s_axi_rvalid_o;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= spio_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o <= spio_pkg::RESP_OKAY;
         unique case (s_axi_araddr_i)
            spio_pkg::OFS_DIR:
               s_axi_rdata_o <= {16'h0000, pin_direction_reg_q};
            spio_pkg::OFS_LAT:
               s_axi_rdata_o <= {16'h0000, output_latch_reg_q};
            spio_pkg::OFS_LVL:
               s_axi_rdata_o <= {16'h0000, pin_level_reg};
            spio_pkg::OFS_ANA:
               s_axi_rdata_o <= {16'h0000, analog_pin_config_reg_q};
            default: begin
               s_axi_rdata_o <= 32'h0000_0000;
               s_axi_rresp_o <= spio_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_periph_owns_pad: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      periph_drive_i[0] |-> pad_oe_o[0] && pad_out_o[0] == periph_out_i[0])
      else $error("Peripheral lost pad");
   chk_port_owns_pad: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !periph_drive_i[0] |-> pad_oe_o[0] == !pin_direction_reg_q[0])
      else $error("Port lost pad");
   chk_dir_out_data: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (!periph_drive_i[1] && !pin_direction_reg_q[1]) |->
      pad_out_o[1] == output_latch_reg_q[1])
      else $error("Latch not on pad");
   chk_reset_inputs: assert property (@(posedge mclk_i)
      $past(rst_i) |-> pin_direction_reg_q == (spio_pkg::DIR_RST &
      spio_pkg::IMPL_MASK) && pad_oe_o == (periph_drive_i &
      spio_pkg::IMPL_MASK))
      else $error("Pins not inputs after reset");
   sequence lvl_write_s;
      wr_fire && wr_addr == spio_pkg::OFS_LVL && wr_strb == 4'hf;
   endsequence
   chk_level_to_latch: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      lvl_write_s |=> output_latch_reg_q == ($past(wr_data[15:0]) &
      spio_pkg::IMPL_MASK))
      else $error("Level write missed latch");
   chk_analog_low: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (pin_level_reg & analog_sel) == '0)
      else $error("Analog pin reads high");
   chk_analog_dir: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (analog_input_pins_o & ~pin_direction_reg_q) == '0)
      else $error("Output pin routed to converter");
   chk_sample_lag: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !$past(rst_i) |-> pin_sample_q == ($past(pad_in_i) &
      spio_pkg::IMPL_MASK))
      else $error("Sampler lag wrong");
   chk_read_resp: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("Read not answered");
   chk_unimpl_zero: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ((pin_direction_reg_q | output_latch_reg_q) & ~spio_pkg::IMPL_MASK)
      == '0)
      else $error("Unimplemented bit set");
   chk_write_resp: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      wr_fire |=> s_axi_bvalid_o)
      else $error("Write not answered");
   chk_level_unimpl: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (pin_level_reg & ~spio_pkg::IMPL_MASK) == '0)
      else $error("Absent level bit set");
   // Readies must drop while a response waits, or a write is lost
   chk_no_take_busy: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("Write taken while response waits");

   // ****************************************************************
   // Register write and read checks
   // ****************************************************************
   sequence lat_write_s;
      wr_fire && wr_addr == spio_pkg::OFS_LAT && wr_strb == 4'hf;
   endsequence
   sequence dir_write_s;
      wr_fire && wr_addr == spio_pkg::OFS_DIR && wr_strb == 4'hf;
   endsequence
   sequence rd_take_s;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   chk_latch_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      lat_write_s |=> output_latch_reg_q == ($past(wr_data[15:0]) &
      spio_pkg::IMPL_MASK))
      else $error("Latch write lost");
   chk_latch_only: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      lat_write_s |=> $stable(pin_direction_reg_q) &&
      $stable(analog_pin_config_reg_q))
      else $error("Latch write touched other register");
   chk_dir_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      dir_write_s |=> pin_direction_reg_q == ($past(wr_data[15:0]) &
      spio_pkg::IMPL_MASK))
      else $error("Direction write lost");
   chk_rd_latch: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rd_take_s ##0 s_axi_araddr_i == spio_pkg::OFS_LAT |=>
      s_axi_rdata_o == {16'h0000, $past(output_latch_reg_q)})
      else $error("Latch read wrong");
   chk_rd_level: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rd_take_s ##0 s_axi_araddr_i == spio_pkg::OFS_LVL |=>
      s_axi_rdata_o == {16'h0000, $past(pin_level_reg)})
      else $error("Level read wrong");
   chk_rd_dir: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rd_take_s ##0 s_axi_araddr_i == spio_pkg::OFS_DIR |=>
      s_axi_rdata_o == {16'h0000, $past(pin_direction_reg_q)})
      else $error("Direction read wrong");

   // ****************************************************************
   // Per-pin pad checks
   // ****************************************************************
   // Bit checks above watch pins 0 and 1 only; these cover every pin of the port
   generate
      for (g = 0; g < W; g++) begin : g_chk
         chk_pin_periph: assert property (
            @(posedge mclk_i) disable iff (rst_i)
            periph_drive_i[g] |->
            pad_oe_o[g] && pad_out_o[g] == periph_out_i[g])
            else $error("Peripheral not on pad");
         chk_pin_port_oe: assert property (
            @(posedge mclk_i) disable iff (rst_i)
            !periph_drive_i[g] |-> pad_oe_o[g] == !pin_direction_reg_q[g])
            else $error("Pad enable not from direction");
         chk_pin_port_out: assert property (
            @(posedge mclk_i) disable iff (rst_i)
            !periph_drive_i[g] && !pin_direction_reg_q[g] |->
            pad_out_o[g] == output_latch_reg_q[g])
            else $error("Pad data not from latch");
      end
   endgenerate
endmodule
`default_nettype wire

// *** verilog/spio_pkg.sv ***
/*
 * Package for the shared parallel I/O port: register offsets, widths,
 * reset values and the implemented-bit mask.
 * Assumes an AXI4-Lite slave with 32-bit data, one register per word.
 */
`default_nettype none
package spio_pkg;
   localparam int PIN_W = 16;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_DIR = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_LAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_LVL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ANA = 8'h0c;
   // Bits present on this port; absent bits are held at zero
   localparam logic [PIN_W-1:0] IMPL_MASK = 16'hffff;
   localparam logic [PIN_W-1:0] DIR_RST = 16'hffff;
   localparam logic [PIN_W-1:0] LAT_RST = 16'h0000;
   localparam logic [PIN_W-1:0] ANA_RST = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// *** tb/spio_pad_model.sv ***
/*
 * Pad model for the port bench: resolves each pin from the port drive.
 * Assumes outside levels come from the bench wherever no one drives.
 */
`default_nettype none
module spio_pad_model (
   input wire logic [spio_pkg::PIN_W-1:0] pad_out_i,
   input wire logic [spio_pkg::PIN_W-1:0] pad_oe_i,
   input wire logic [spio_pkg::PIN_W-1:0] ext_lvl_i,
   output logic [spio_pkg::PIN_W-1:0] pad_in_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Driven pins read back their own drive, the rest the outside level
   assign pad_in_o = (pad_out_i & pad_oe_i) | (ext_lvl_i & ~pad_oe_i);
endmodule
`default_nettype wire

// *** tb/spio_port_bench.sv ***
/*
 * Self-checking bench for the shared parallel I/O port.
 * Assumes the AXI4-Lite slave of the verilog folder and the pad model of this folder.
 */
`default_nettype none
module spio_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************
   // Signals
   // ************************************************
   logic clk = 0, rst = 1, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0;
   logic awr, wr_o, bv, arr, rv;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd_o;
   logic [1:0] br, rr;
   logic [15:0] pin, pout, poe, pdrv = 16'h0, pdat = 16'h0, ext = 16'h0;
   logic [15:0] ana;
   int failures = 0, n_checks = 0;
   spio_port spio_port_i (.mclk_i(clk), .rst_i(rst),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wr_o), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bq), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rd_o), .s_axi_rresp_o(rr),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rq), .pad_in_i(pin),
      .pad_out_o(pout), .pad_oe_o(poe), .periph_drive_i(pdrv),
      .periph_out_i(pdat), .analog_input_pins_o(ana));
   spio_pad_model spio_pad_model_i (.pad_out_i(pout), .pad_oe_i(poe),
      .ext_lvl_i(ext), .pad_in_o(pin));
   initial begin
      forever #10 clk = ~clk;
   end
   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Master holds each channel until its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge clk);
      awa <= a; wd <= d; awv <= 1; wv <= 1; bq <= 1;
      forever begin
         @(posedge clk);
         if (awv && awr) awv <= 0;
         if (wv && wr_o) wv <= 0;
         if (bv) break;
      end
      bq <= 0;
      chk({30'h0, br}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      @(posedge clk);
      ara <= a; arv <= 1; rq <= 1;
      forever begin
         @(posedge clk);
         if (arv && arr) arv <= 0;
         if (rv) break;
      end
      rq <= 0;
      chk(rd_o, ed);
      chk({30'h0, rr}, {30'h0, er});
   endtask
   task automatic pins(input logic [15:0] eoe, input logic [15:0] eout);
      @(negedge clk);
      chk({16'h0, poe}, {16'h0, eoe});
      chk({16'h0, pout & poe}, {16'h0, eout});
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ************************************************
   // Scenarios
   // ************************************************
   localparam logic [1:0] OK = spio_pkg::RESP_OKAY;
   localparam logic [1:0] SE = spio_pkg::RESP_SLVERR;
   task automatic t_reset;
      pins(16'h0000, 16'h0000);
      rd(spio_pkg::OFS_DIR, 32'h0000ffff, OK);
      rd(spio_pkg::OFS_LAT, 32'h0, OK);
      rd(spio_pkg::OFS_ANA, 32'h0, OK);
   endtask
   task automatic t_port;
      ext <= 16'h3c00;
      wr(spio_pkg::OFS_DIR, 32'h0000ff00, OK);
      wr(spio_pkg::OFS_LAT, 32'h000000a5, OK);
      pins(16'h00ff, 16'h00a5);
      rd(spio_pkg::OFS_LAT, 32'h000000a5, OK);
      rd(spio_pkg::OFS_LVL, 32'h00003ca5, OK);
   endtask
   task automatic t_periph;
      @(posedge clk);
      pdrv <= 16'h0103;
      pdat <= 16'h0102;
      pins(16'h01ff, 16'h01a6);
      rd(spio_pkg::OFS_LVL, 32'h00003da6, OK);
      @(posedge clk);
      pdrv <= 16'h0000;
      pins(16'h00ff, 16'h00a5);
   endtask
   task automatic t_analog;
      wr(spio_pkg::OFS_LVL, 32'h00000011, OK);
      rd(spio_pkg::OFS_LAT, 32'h00000011, OK);
      // Analog bits on inputs only; bit 0 stays a digital output
      wr(spio_pkg::OFS_ANA, 32'h00000f01, OK);
      @(negedge clk);
      chk({16'h0, ana}, 32'h00000f00);
      rd(spio_pkg::OFS_LVL, 32'h00003011, OK);
   endtask
   task automatic t_unmapped;
      wr(8'h10, 32'h00000000, SE);
      rd(8'h10, 32'h00000000, SE);
      rd(spio_pkg::OFS_DIR, 32'h0000ff00, OK);
   endtask
   // Mid-run reset: every pin must fall back to input
   task automatic t_rereset;
      @(posedge clk);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      pins(16'h0000, 16'h0000);
      rd(spio_pkg::OFS_DIR, 32'h0000ffff, OK);
      rd(spio_pkg::OFS_LAT, 32'h0, OK);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      t_reset();
      t_port();
      t_periph();
      t_analog();
      t_unmapped();
      t_rereset();
      close_out();
   end
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      close_out();
   end
endmodule
`default_nettype wire
